// ==== src/i2c_slave_transmit_and_ten_bit_rx.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Read match: direction set, address buffered, ACK
// - After read ACK, clear release, hold SCL
// - Buffer write loads shifter; software then releases
// - Data bits shift out on SCL falls
// - Master ACK latched at ninth rise
// - Master NACK ends transfer, go idle
// - After NACK no hold, event still set
// - After master ACK, stretch until released
// - Event flag at ninth fall, sticky
// - Collision while sending: flag, go idle
// - Start sets start flag, optional event
// - Address hold: clear release, event, before ACK
// - Software-chosen ACK value driven after hold
// - Hold mode read: clear release after ACK
// - 10-bit high write match: update flag, hold
// - Address write releases SCL for low byte
// - Stretch enable holds SCL after data bytes
// - 10-bit holds same as 7-bit holds
// - 10-bit high byte compare against prefix
// - Address write clears update flag
module i2c_slave_transmit_and_ten_bit_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus pins
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Configuration
    input wire logic tenBitMode,
    input wire logic addressHoldEnable,
    input wire logic dataHoldEnable,
    input wire logic stretchEnable,
    input wire logic slaveCollisionDetectEnable,
    input wire logic startInterruptEnable,
    input wire logic ackValueOut,
    // Software strobes
    input wire logic bufWrite,
    input wire logic [i2c_slave_pkg::BYTE_W-1:0] bufWriteData,
    input wire logic bufRead,
    input wire logic addrWrite,
    input wire logic [i2c_slave_pkg::BYTE_W-1:0] addrWriteData,
    input wire logic clockReleaseSet,
    input wire logic eventClear,
    input wire logic collisionClear,
    // Status
    output logic [i2c_slave_pkg::BYTE_W-1:0] rxTxBuffer,
    output logic [i2c_slave_pkg::BYTE_W-1:0] slaveAddressReg,
    output logic clockRelease,
    output logic readDirection,
    output logic dataNotAddress,
    output logic ackTimeFlag,
    output logic masterAckStatus,
    output logic serialEventFlag,
    output logic busCollisionFlag,
    output logic startSeen,
    output logic stopSeen,
    output logic bufferFull,
    output logic addressUpdateNeeded
);
    import i2c_slave_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Pin synchronisers and edges
    // ****************************************
    logic sclMeta, sclS, sclPrev;
    logic sdaMeta, sdaS, sdaPrev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclMeta <= 1'b1;
            sclS <= 1'b1;
            sclPrev <= 1'b1;
            sdaMeta <= 1'b1;
            sdaS <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclMeta <= sclIn;
            sclS <= sclMeta;
            sclPrev <= sclS;
            sdaMeta <= sdaIn;
            sdaS <= sdaMeta;
            sdaPrev <= sdaS;
        end
    end

    logic sclRise, sclFall, startCond, stopCond;
    assign sclRise = sclS & ~sclPrev;
    assign sclFall = ~sclS & sclPrev;
    assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopCond = sclS & sclPrev & ~sdaPrev & sdaS;

    // ****************************************
    // Protocol engine
    // ****************************************
    state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftTx;
    logic ackPhase, swAck, ackLocal, tenBitMatched;
    logic evtPulse, bclPulse, ckpClr, bfSet, uaSet;
    logic hiMatch, loMatch, ackGiven, txCollide;

    assign hiMatch = tenBitMode ?
        (shiftIn[7:1] == {TEN_BIT_PREFIX, slaveAddressReg[HI_ADDR_MSB:HI_ADDR_LSB]}) &&
        (!shiftIn[RW_BIT] || tenBitMatched) :
        (shiftIn[7:1] == slaveAddressReg[7:1]);
    assign loMatch = (shiftIn == slaveAddressReg);
    assign ackGiven = swAck ? ~ackValueOut : ackLocal;
    assign txCollide = (state == ST_TX) && (bitCnt < BYTE_BITS) && shiftTx[7] && !sdaS;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bitCnt <= CNT_ZERO;
            shiftIn <= BYTE_RESET;
            shiftTx <= TX_IDLE;
            rxTxBuffer <= BYTE_RESET;
            ackPhase <= 1'b0;
            swAck <= 1'b0;
            ackLocal <= 1'b0;
            tenBitMatched <= 1'b0;
            readDirection <= 1'b0;
            dataNotAddress <= 1'b0;
            ackTimeFlag <= 1'b0;
            masterAckStatus <= 1'b0;
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
            evtPulse <= 1'b0;
            bclPulse <= 1'b0;
            ckpClr <= 1'b0;
            bfSet <= 1'b0;
            uaSet <= 1'b0;
        end else begin
            evtPulse <= 1'b0;
            bclPulse <= 1'b0;
            ckpClr <= 1'b0;
            bfSet <= 1'b0;
            uaSet <= 1'b0;
            if (startCond) begin
                state <= ST_ADDR_HI;
                bitCnt <= CNT_ZERO;
                ackPhase <= 1'b0;
                ackTimeFlag <= 1'b0;
                startSeen <= 1'b1;
                stopSeen <= 1'b0;
                evtPulse <= startInterruptEnable;
            end else if (stopCond) begin
                state <= ST_IDLE;
                ackPhase <= 1'b0;
                ackTimeFlag <= 1'b0;
                tenBitMatched <= 1'b0;
                startSeen <= 1'b0;
                stopSeen <= 1'b1;
            end else if (state != ST_IDLE && sclRise) begin
                bitCnt <= 4'(bitCnt + CNT_ONE);
                if (bitCnt < BYTE_BITS) begin
                    shiftIn <= {shiftIn[6:0], sdaS};
                end
                if (txCollide && slaveCollisionDetectEnable) begin
                    bclPulse <= 1'b1;
                    state <= ST_IDLE;
                end
                if (state == ST_TX && bitCnt == BYTE_BITS) begin
                    masterAckStatus <= sdaS;
                end
            end else if (state != ST_IDLE && sclFall) begin
                if (bitCnt == BYTE_BITS) begin
                    case (state)
                        ST_ADDR_HI: begin
                            if (hiMatch) begin
                                rxTxBuffer <= shiftIn;
                                bfSet <= 1'b1;
                                readDirection <= shiftIn[RW_BIT];
                                dataNotAddress <= 1'b0;
                                ackPhase <= 1'b1;
                                ackLocal <= 1'b1;
                                swAck <= addressHoldEnable;
                                if (addressHoldEnable) begin
                                    ckpClr <= 1'b1;
                                    evtPulse <= 1'b1;
                                    ackTimeFlag <= 1'b1;
                                end
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                        ST_ADDR_LO: begin
                            rxTxBuffer <= shiftIn;
                            bfSet <= 1'b1;
                            ackPhase <= 1'b1;
                            ackLocal <= loMatch;
                            swAck <= addressHoldEnable & loMatch;
                            if (addressHoldEnable && loMatch) begin
                                ckpClr <= 1'b1;
                                evtPulse <= 1'b1;
                                ackTimeFlag <= 1'b1;
                            end
                        end
                        ST_RX: begin
                            rxTxBuffer <= shiftIn;
                            bfSet <= 1'b1;
                            dataNotAddress <= 1'b1;
                            ackPhase <= 1'b1;
                            ackLocal <= 1'b1;
                            swAck <= dataHoldEnable;
                            if (dataHoldEnable) begin
                                ckpClr <= 1'b1;
                                evtPulse <= 1'b1;
                                ackTimeFlag <= 1'b1;
                            end
                        end
                        ST_TX: begin
                            shiftTx <= {shiftTx[6:0], 1'b1};
                        end
                        default: begin
                        end
                    endcase
                end else if (bitCnt == ACK_BIT) begin
                    bitCnt <= CNT_ZERO;
                    ackPhase <= 1'b0;
                    ackTimeFlag <= 1'b0;
                    case (state)
                        ST_ADDR_HI: begin
                            if (!ackGiven) begin
                                state <= ST_IDLE;
                            end else if (readDirection) begin
                                state <= ST_TX;
                                ckpClr <= 1'b1;
                                evtPulse <= 1'b1;
                            end else if (tenBitMode) begin
                                state <= ST_ADDR_LO;
                                uaSet <= 1'b1;
                                evtPulse <= 1'b1;
                            end else begin
                                state <= ST_RX;
                                evtPulse <= 1'b1;
                            end
                        end
                        ST_ADDR_LO: begin
                            uaSet <= 1'b1;
                            evtPulse <= 1'b1;
                            if (ackGiven && loMatch) begin
                                tenBitMatched <= 1'b1;
                                state <= ST_RX;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                        ST_RX: begin
                            evtPulse <= ackGiven;
                            if (stretchEnable) begin
                                ckpClr <= 1'b1;
                            end
                            if (!ackGiven) begin
                                state <= ST_IDLE;
                            end
                        end
                        ST_TX: begin
                            evtPulse <= 1'b1;
                            dataNotAddress <= 1'b1;
                            if (masterAckStatus) begin
                                state <= ST_IDLE;
                            end else begin
                                ckpClr <= 1'b1;
                            end
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end else if (state == ST_TX && bitCnt != CNT_ZERO) begin
                    shiftTx <= {shiftTx[6:0], 1'b1};
                end
            end
            if (bufWrite) begin
                shiftTx <= bufWriteData;
                rxTxBuffer <= bufWriteData;
            end
        end
    end

    // ****************************************
    // Software-visible flags
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serialEventFlag <= 1'b0;
            busCollisionFlag <= 1'b0;
            bufferFull <= 1'b0;
        end else begin
            serialEventFlag <= evtPulse | (serialEventFlag & ~eventClear);
            busCollisionFlag <= bclPulse | (busCollisionFlag & ~collisionClear);
            bufferFull <= bfSet | bufWrite | (bufferFull & ~bufRead);
        end
    end

    // Hardware clear beats a software set in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clockRelease <= 1'b1;
        end else if (ckpClr) begin
            clockRelease <= 1'b0;
        end else if (clockReleaseSet) begin
            clockRelease <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slaveAddressReg <= ADDR_RESET;
            addressUpdateNeeded <= 1'b0;
        end else begin
            if (addrWrite) begin
                slaveAddressReg <= addrWriteData;
            end
            addressUpdateNeeded <= uaSet | (addressUpdateNeeded & ~addrWrite);
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    logic holdReq, next_sdaOe;
    assign holdReq = ((state != ST_IDLE) && !clockRelease) || addressUpdateNeeded;
    assign next_sdaOe = ackPhase ? ackGiven :
        ((state == ST_TX) && (bitCnt < BYTE_BITS) && !shiftTx[7]);
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    // Grab SCL only once it is already low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            sdaOe <= next_sdaOe;
            if (!holdReq) begin
                sclOe <= 1'b0;
            end else if (!sclS) begin
                sclOe <= 1'b1;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    read_ack_hold_a: assert property (
        (sclFall && state == ST_ADDR_HI && bitCnt == ACK_BIT && readDirection && ackGiven)
        |-> ##2 (!clockRelease && serialEventFlag && state == ST_TX))
        else $error("read ack did not hold clock");
    master_ack_latch_a: assert property (
        (sclRise && state == ST_TX && bitCnt == BYTE_BITS && !startCond && !stopCond)
        |=> (masterAckStatus == $past(sdaS)))
        else $error("master ack not latched");
    nack_goes_idle_a: assert property (
        (sclFall && state == ST_TX && bitCnt == ACK_BIT && masterAckStatus && !startCond && !stopCond)
        |=> (state == ST_IDLE) ##1 serialEventFlag)
        else $error("nack did not end transfer");
    ack_stretch_a: assert property (
        (sclFall && state == ST_TX && bitCnt == ACK_BIT && !masterAckStatus && !startCond && !stopCond)
        |-> ##2 !clockRelease)
        else $error("no stretch after master ack");
    collision_flag_a: assert property (
        (sclRise && txCollide && slaveCollisionDetectEnable && !startCond && !stopCond)
        |=> (state == ST_IDLE) ##1 busCollisionFlag)
        else $error("collision not flagged");
    start_flag_a: assert property (
        startCond |=> (startSeen && state == ST_ADDR_HI && bitCnt == CNT_ZERO))
        else $error("start not recorded");
    addr_hold_a: assert property (
        (sclFall && state == ST_ADDR_HI && bitCnt == BYTE_BITS && hiMatch && addressHoldEnable
         && !startCond && !stopCond)
        |-> ##2 (!clockRelease && serialEventFlag && ackTimeFlag))
        else $error("address hold missing");
    sw_ack_drive_a: assert property (
        (ackPhase && swAck && ackValueOut) |=> !sdaOe)
        else $error("software nack not driven");
    buf_load_a: assert property (
        bufWrite |=> (shiftTx == $past(bufWriteData) && bufferFull))
        else $error("buffer write did not load shifter");
    ua_clear_a: assert property (
        (addrWrite && !uaSet) |=> !addressUpdateNeeded)
        else $error("update flag not cleared");
    scl_hold_a: assert property (
        (holdReq && !sclS) |=> sclOe)
        else $error("scl not held");

    read_ack_c: cover property (sclFall && state == ST_ADDR_HI && bitCnt == ACK_BIT && readDirection && ackGiven);
    nack_end_c: cover property (sclFall && state == ST_TX && bitCnt == ACK_BIT && masterAckStatus);
    collision_c: cover property (bclPulse);
    ten_bit_lo_c: cover property (state == ST_ADDR_LO && addrWrite);

endmodule : i2c_slave_transmit_and_ten_bit_rx

// ==== shared/i2c_slave_pkg.sv ====
package i2c_slave_pkg;

    // ****************************************
    // Widths and bit positions
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int HI_ADDR_MSB = 2;
    localparam int HI_ADDR_LSB = 1;
    localparam int RW_BIT = 0;

    // Rising-edge counts inside one byte
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h9;

    // Top five bits of the first byte of a 10-bit address
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

    // Reset values
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] TX_IDLE = 8'hFF;

    // ****************************************
    // Protocol states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR_HI = 3'b001,
        ST_ADDR_LO = 3'b010,
        ST_RX = 3'b011,
        ST_TX = 3'b100
    } state_t;

endpackage : i2c_slave_pkg

// ==== verif/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
    // Clock
    input wire logic clk,
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    output logic sclLow,
    output logic sdaLow,
    // Read result
    output logic rdValid,
    output logic [7:0] rdByte
);
    // ****************************************
    // Bus cycles
    // ****************************************
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        rdValid = 1'b0;
        rdByte = 8'h00;
    end

    // Release SCL, then wait out any stretching by the slave
    task automatic relScl();
        int n;
        sclLow <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (scl !== 1'b1 && n < 4000);
    endtask : relScl

    // Long low phase covers the slave's synchroniser and answer delay
    task automatic pulse(input logic v, output logic s);
        @(posedge clk);
        sdaLow <= ~v;
        repeat (4) @(posedge clk);
        relScl();
        repeat (2) @(posedge clk);
        s = sda;
        sclLow <= 1'b1;
    endtask : pulse

    task automatic start();
        sdaLow <= 1'b0;
        relScl();
        repeat (4) @(posedge clk);
        sdaLow <= 1'b1;
        repeat (4) @(posedge clk);
        sclLow <= 1'b1;
    endtask : start

    task automatic stop();
        @(posedge clk);
        sdaLow <= 1'b1;
        repeat (5) @(posedge clk);
        relScl();
        repeat (4) @(posedge clk);
        sdaLow <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : stop

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(b[i], s);
        pulse(1'b1, ack);
    endtask : sendByte

    // Clash pulls SDA low against the slave's first bit
    task automatic readByte(input logic ackBit, input logic clash, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) pulse((i == 7) ? ~clash : 1'b1, b[i]);
        pulse(ackBit, s);
        rdByte <= b;
        rdValid <= ~clash;
        @(posedge clk);
        rdValid <= 1'b0;
    endtask : readByte
endmodule : i2c_master_model

// ==== verif/test_i2c_slave_transmit_and_ten_bit_rx.sv ====
`timescale 1ns/1ps
module test_i2c_slave_transmit_and_ten_bit_rx;
    // ****************************************
    // Signals and models
    // ****************************************
    localparam int WR = 0, RD = 1, AD = 2, REL = 3, EVC = 4, COL = 5;
    logic clk, rst_n, sclLow, sdaLow, rdValid, sclOe, sdaOe, a;
    logic tenBitMode, addressHoldEnable, dataHoldEnable, stretchEnable;
    logic slaveCollisionDetectEnable, startInterruptEnable, ackValueOut;
    logic [5:0] stb;
    logic [7:0] bufWriteData, addrWriteData, rdByte, rxTxBuffer, slaveAddressReg, d, r;
    logic clockRelease, readDirection, ackTimeFlag, masterAckStatus, serialEventFlag;
    logic busCollisionFlag, startSeen, bufferFull, addressUpdateNeeded;
    logic dataNotAddress, stopSeen;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    logic [7:0] expQ[$];
    wire sclLine = ~(sclOe | sclLow);
    wire sdaLine = ~(sdaOe | sdaLow);

    i2c_slave_transmit_and_ten_bit_rx i2c_slave_transmit_and_ten_bit_rx_inst (
        .clk, .rst_n, .sclIn(sclLine), .sclOut(), .sclOe, .sdaIn(sdaLine), .sdaOut(), .sdaOe,
        .tenBitMode, .addressHoldEnable, .dataHoldEnable, .stretchEnable,
        .slaveCollisionDetectEnable, .startInterruptEnable, .ackValueOut,
        .bufWrite(stb[WR]), .bufWriteData, .bufRead(stb[RD]), .addrWrite(stb[AD]), .addrWriteData,
        .clockReleaseSet(stb[REL]), .eventClear(stb[EVC]), .collisionClear(stb[COL]),
        .rxTxBuffer, .slaveAddressReg, .clockRelease, .readDirection, .dataNotAddress,
        .ackTimeFlag, .masterAckStatus, .serialEventFlag, .busCollisionFlag, .startSeen,
        .stopSeen, .bufferFull, .addressUpdateNeeded
    );
    i2c_master_model m (.clk, .scl(sclLine), .sda(sdaLine), .sclLow, .sdaLow, .rdValid, .rdByte);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************
    // Checking and software tasks
    // ****************************************
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic sw(input int k, input logic [7:0] v);
        @(posedge clk);
        stb[k] <= 1'b1;
        bufWriteData <= v;
        addrWriteData <= v;
        @(posedge clk);
        stb <= 6'h00;
    endtask : sw

    task automatic settle();
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic readOne(input logic ackBit, input logic clash);
        d = $urandom;
        if (clash) d[7] = 1'b1;
        else expQ.push_back(d);
        fork
            m.readByte(ackBit, clash, r);
            begin
                sw(WR, d);
                sw(REL, 8'h00);
            end
        join
        settle();
    endtask : readOne

    always @(posedge clk) begin
        if (rdValid) chk(rdByte, expQ.pop_front());
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        {tenBitMode, addressHoldEnable, dataHoldEnable, stretchEnable} = 4'h0;
        {slaveCollisionDetectEnable, startInterruptEnable, ackValueOut} = 3'h0;
        {rst_n, stb, bufWriteData, addrWriteData} = 23'h000000;
        d = $urandom(32'h570c4a3f);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(clockRelease, 8'h01);
        chk(sclOe, 8'h00);
        startInterruptEnable <= 1'b1;
        sw(AD, 8'hA4);
        m.start();
        settle();
        chk(startSeen, 8'h01);
        chk(serialEventFlag, 8'h01);
        sw(EVC, 8'h00);
        m.sendByte(8'hA5, a);
        settle();
        chk(a, 8'h00);
        chk(readDirection, 8'h01);
        chk(rxTxBuffer, 8'hA5);
        chk({bufferFull, dataNotAddress}, 8'h02);
        chk(clockRelease, 8'h00);
        chk(sclOe, 8'h01);
        chk(serialEventFlag, 8'h01);
        sw(RD, 8'h00);
        sw(EVC, 8'h00);
        chk(bufferFull, 8'h00);
        for (int i = 0; i < 2; i++) begin
            readOne(i[0], 1'b0);
            chk(masterAckStatus, i[7:0]);
            chk(serialEventFlag, 8'h01);
            chk(sclOe, {7'h00, i == 0});
            sw(EVC, 8'h00);
        end
        chk({dataNotAddress, sdaOe}, 8'h02);
        m.stop();
        chk(stopSeen, 8'h01);
        addressHoldEnable <= 1'b1;
        for (int v = 1; v >= 0; v--) begin
            ackValueOut <= v[0];
            m.start();
            sw(EVC, 8'h00);
            fork
                m.sendByte(8'hA5, a);
                begin
                    for (int n = 0; n < 4000 && clockRelease !== 1'b0; n++) @(posedge clk);
                    chk(ackTimeFlag, 8'h01);
                    chk(serialEventFlag, 8'h01);
                    chk({dataNotAddress, sdaOe}, {7'h00, ~v[0]});
                    sw(EVC, 8'h00);
                    sw(REL, 8'h00);
                end
            join
            settle();
            chk(a, v[7:0]);
            if (v == 0) begin
                chk(clockRelease, 8'h00);
                chk(serialEventFlag, 8'h01);
                readOne(1'b1, 1'b0);
            end
            m.stop();
        end
        addressHoldEnable <= 1'b0;
        slaveCollisionDetectEnable <= 1'b1;
        m.start();
        m.sendByte(8'hA5, a);
        settle();
        readOne(1'b1, 1'b1);
        chk(busCollisionFlag, 8'h01);
        chk({sdaOe, sclOe}, 8'h00);
        sw(COL, 8'h00);
        m.stop();
        tenBitMode <= 1'b1;
        stretchEnable <= 1'b1;
        sw(AD, 8'h06);
        m.start();
        sw(EVC, 8'h00);
        m.sendByte(8'hF6, a);
        settle();
        chk(a, 8'h00);
        chk({addressUpdateNeeded, serialEventFlag, sclOe}, 8'h07);
        sw(EVC, 8'h00);
        sw(AD, 8'h3C);
        settle();
        chk({addressUpdateNeeded, sclOe}, 8'h00);
        m.sendByte(8'h3C, a);
        settle();
        chk({a, addressUpdateNeeded}, 8'h01);
        sw(AD, 8'h06);
        d = $urandom;
        m.sendByte(d, a);
        settle();
        chk(rxTxBuffer, d);
        chk({clockRelease, sclOe}, 8'h01);
        sw(REL, 8'h00);
        m.start();
        m.sendByte(8'hF7, a);
        settle();
        chk({a, readDirection}, 8'h01);
        readOne(1'b1, 1'b0);
        m.stop();
        chk(8'(expQ.size()), 8'h00);
        end_of_test();
    end
endmodule : test_i2c_slave_transmit_and_ten_bit_rx
